// [shared/ten_bit_tx_pkg.sv]
// constants and carrier types of the ten-bit address transmit controller
package ten_bit_tx_pkg;

    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;

    // ten-bit header prefix on the top five bits of the first byte
    localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;
    localparam int PREFIX_HI = 7;
    localparam int PREFIX_LO = 3;
    localparam int RW_BIT = 0;
    localparam logic WRITE_DIR = 1'h0;
    localparam int MSB = 7;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [2:0] FIRST_BIT = 3'h0;

    // bit timing on the link clock
    localparam int LINK_PERIOD_PS = 6000;
    localparam int QUARTER_NS = 2500;
    localparam int QUARTER_CYC_INT = (QUARTER_NS * 1000) / LINK_PERIOD_PS;
    localparam logic [11:0] QUARTER_LAST = 12'(QUARTER_CYC_INT - 1);

    // quarter phases of one bit cell
    localparam logic [1:0] PH_SETUP = 2'h0;
    localparam logic [1:0] PH_RISE = 2'h1;
    localparam logic [1:0] PH_HIGH = 2'h2;
    localparam logic [1:0] PH_FALL = 2'h3;

    typedef enum logic [6:0] {
        S_IDLE = 7'h01,
        S_START = 7'h02,
        S_BIT = 7'h04,
        S_ACK = 7'h08,
        S_WAIT = 7'h10,
        S_STOP = 7'h20,
        S_SPARE = 7'h40
    } link_state_e;

    typedef struct packed {
        logic transmit_data_empty;
        logic ack;
        logic nack_interrupt_flag;
        logic stop_pending;
        logic header_ten_bit_write;
    } tx_status_s;

endpackage

// [hw/ten_bit_tx.sv]
// ten-bit address transmit controller with its data fifo
`timescale 1ns/1ps

module tx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic flush,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic [AW:0] cnt_d;
    logic full_q;
    logic push;
    logic pop;

    assign in_ready = ~full_q;
    assign out_valid = (cnt_q != '0);
    assign out_data = mem[rd_q];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_comb begin
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || flush) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            full_q <= 1'b0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            cnt_q <= cnt_d;
            full_q <= (cnt_d == FULL_CNT);
        end
    end
endmodule // tx_fifo

// Overview of operation
// RL1: first header byte carries prefix 11110 then the two top address bits.
// RL2: software puts a zero write indicator in the first byte's lowest bit.
// RL3: enable plus transmit interrupt enable raise the interrupt at once when empty.
// RL4: software answers by writing the first address byte, then requests start.
// RL5: on start request, send START, then load data into the shift register.
// RL6: after the first bit leaves on the data line, raise transmit interrupt again.
// RL7: software writes the second byte while remaining first-byte bits shift out.
// RL8: sample the data line in the clock-high after each byte; low sets ack.
// RL9: missing acknowledge sets the nack flag and clears the ack status.
// RL10: on nack software sets stop and flush and clears transmit interrupt enable.
// RL11: after stop request, send STOP and clear stop request and nack flag.
// RL12: after ack, load and shift the next byte; interrupt after its first bit.
// RL13: software supplies a data byte while the second header byte finishes shifting.
// RL14: after the header, data bytes follow with identical ack and interrupt handling.
// RL15: transmit empty clears on data write and sets when the byte is taken; the code sets it after a byte's first bit, and only if the fifo is empty.
module ten_bit_tx
    import ten_bit_tx_pkg::*;
(
    // system clock and reset
    input wire logic clk,
    input wire logic rst,
    // link engine clock
    input wire logic link_clk,
    // control bits
    input wire logic controller_enable,
    input wire logic transmit_interrupt_enable,
    input wire logic start_req,
    input wire logic stop_req,
    input wire logic flush_req,
    // data register writes
    input wire logic data_valid,
    output logic data_ready,
    input wire logic [DATA_W-1:0] data_in,
    // status and interrupt
    output tx_status_s status,
    output logic irq,
    // open-drain bus pins
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe
);
    // system clock domain
    tx_status_s status_q;
    logic irq_q;
    logic ready_q;
    logic start_tg_q;
    logic xack_tg_q;
    logic [DATA_W-1:0] xfer_q;
    logic req_seen_q;
    logic first_bit_seen_q;
    logic ack_seen_c_q;
    logic stop_seen_q;
    logic first_pending_q;
    logic [1:0] req_s_q;
    logic [1:0] first_bit_s_q;
    logic [1:0] ack_s_c_q;
    logic [1:0] stop_s_c_q;
    logic fifo_ready;
    logic fifo_valid;
    logic [DATA_W-1:0] fifo_data;
    logic pop;
    logic push;
    logic ev_first_bit;
    logic ev_ack;
    logic ev_stop_done;

    // link clock domain
    link_state_e state_q;
    logic [1:0] rst_l_q;
    logic [1:0] start_s_q;
    logic [1:0] xack_s_q;
    logic [1:0] stop_s_q;
    logic [1:0] en_s_q;
    logic [1:0] sda_s_q;
    logic start_seen_q;
    logic xack_seen_q;
    logic req_tg_q;
    logic first_bit_tg_q;
    logic ack_tg_q;
    logic ack_val_q;
    logic stop_tg_q;
    logic pending_q;
    logic have_next_q;
    logic [DATA_W-1:0] next_q;
    logic [DATA_W-1:0] shift_q;
    logic [2:0] bitn_q;
    logic [11:0] qcnt_q;
    logic [1:0] phase_q;
    logic tick;
    logic link_rst;
    logic sda_oe_q;
    logic scl_oe_q;
    logic need_fetch;

    assign status = status_q;
    assign irq = irq_q;
    assign data_ready = ready_q;
    assign sda_o = 1'b0 & sda_oe_q;
    assign scl_o = 1'b0 & scl_oe_q;
    assign sda_oe = sda_oe_q;
    assign scl_oe = scl_oe_q;

    // data fifo between the data register and the link engine
    tx_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .flush(flush_req),
        .in_valid(data_valid),
        .in_ready(fifo_ready),
        .in_data(data_in),
        .out_valid(fifo_valid),
        .out_ready(pop),
        .out_data(fifo_data)
    );

    assign push = data_valid & fifo_ready;
    assign pop = fifo_valid & (req_s_q[1] != req_seen_q);
    assign ev_first_bit = first_bit_s_q[1] != first_bit_seen_q;
    assign ev_ack = ack_s_c_q[1] != ack_seen_c_q;
    assign ev_stop_done = stop_s_c_q[1] != stop_seen_q;

    // synchronisers into the system domain
    always_ff @(posedge clk) begin
        req_s_q <= {req_s_q[0], req_tg_q};
        first_bit_s_q <= {first_bit_s_q[0], first_bit_tg_q};
        ack_s_c_q <= {ack_s_c_q[0], ack_tg_q};
        stop_s_c_q <= {stop_s_c_q[0], stop_tg_q};
    end

    // byte hand-off to the link engine
    always_ff @(posedge clk) begin
        if (rst) begin
            req_seen_q <= 1'b0;
            xack_tg_q <= 1'b0;
            xfer_q <= '0;
        end else if (pop) begin
            req_seen_q <= req_s_q[1];
            xfer_q <= fifo_data;
            xack_tg_q <= ~xack_tg_q;
        end
    end

    // start request crossing and header recognition
    always_ff @(posedge clk) begin
        if (rst) begin
            start_tg_q <= 1'b0;
            first_pending_q <= 1'b0;
            status_q.header_ten_bit_write <= 1'b0;
        end else begin
            if (start_req && controller_enable) begin
                start_tg_q <= ~start_tg_q;
                first_pending_q <= 1'b1;
            end else if (pop) begin
                first_pending_q <= 1'b0;
            end
            if (pop && first_pending_q) begin
                status_q.header_ten_bit_write <=
                    (fifo_data[PREFIX_HI:PREFIX_LO] == TEN_BIT_PREFIX) && // RL1
                    (fifo_data[RW_BIT] == WRITE_DIR); // RL2
            end
        end
    end

    // event bookkeeping
    always_ff @(posedge clk) begin
        if (rst) begin
            first_bit_seen_q <= 1'b0;
            ack_seen_c_q <= 1'b0;
            stop_seen_q <= 1'b0;
        end else begin
            first_bit_seen_q <= first_bit_s_q[1];
            ack_seen_c_q <= ack_s_c_q[1];
            stop_seen_q <= stop_s_c_q[1];
        end
    end

    // transmit data empty; the set wins over a same-cycle write
    always_ff @(posedge clk) begin
        if (rst || flush_req) begin
            status_q.transmit_data_empty <= 1'b1;
        end else if (ev_first_bit && !fifo_valid) begin
            status_q.transmit_data_empty <= 1'b1; // RL6 RL12 RL15
        end else if (push) begin
            status_q.transmit_data_empty <= 1'b0; // RL15
        end
    end

    // acknowledge status and nack flag
    always_ff @(posedge clk) begin
        if (rst) begin
            status_q.ack <= 1'b0;
            status_q.nack_interrupt_flag <= 1'b0;
        end else begin
            if (ev_ack) begin
                status_q.ack <= ack_val_q; // RL8 RL9 RL14
            end
            if (ev_ack && !ack_val_q) begin
                status_q.nack_interrupt_flag <= 1'b1; // RL9
            end else if (ev_stop_done) begin
                status_q.nack_interrupt_flag <= 1'b0; // RL11
            end
        end
    end

    // stop request bit, cleared when the stop condition has gone out
    always_ff @(posedge clk) begin
        if (rst) begin
            status_q.stop_pending <= 1'b0;
        end else if (stop_req) begin
            status_q.stop_pending <= 1'b1;
        end else if (ev_stop_done) begin
            status_q.stop_pending <= 1'b0; // RL11
        end
    end

    // interrupt and write ready
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_q <= 1'b0;
            ready_q <= 1'b0;
        end else begin
            irq_q <= controller_enable & transmit_interrupt_enable &
                     (status_q.transmit_data_empty | status_q.nack_interrupt_flag); // RL3 RL6
            ready_q <= fifo_ready;
        end
    end

    // link domain reset and synchronisers
    assign link_rst = rst_l_q[1];

    always_ff @(posedge link_clk) begin
        rst_l_q <= {rst_l_q[0], rst};
        start_s_q <= {start_s_q[0], start_tg_q};
        xack_s_q <= {xack_s_q[0], xack_tg_q};
        stop_s_q <= {stop_s_q[0], status_q.stop_pending};
        en_s_q <= {en_s_q[0], controller_enable};
        sda_s_q <= {sda_s_q[0], sda_i};
    end

    // quarter-bit timer
    assign tick = (qcnt_q == QUARTER_LAST);

    always_ff @(posedge link_clk) begin
        if (link_rst || state_q == S_IDLE) begin
            qcnt_q <= '0;
            phase_q <= PH_SETUP;
        end else if (tick) begin
            qcnt_q <= '0;
            phase_q <= phase_q + 1'b1;
        end else begin
            qcnt_q <= qcnt_q + 1'b1;
        end
    end

    assign need_fetch = !have_next_q && !pending_q;

    // link engine
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            state_q <= S_IDLE;
            start_seen_q <= 1'b0;
            xack_seen_q <= 1'b0;
            req_tg_q <= 1'b0;
            first_bit_tg_q <= 1'b0;
            ack_tg_q <= 1'b0;
            ack_val_q <= 1'b0;
            stop_tg_q <= 1'b0;
            pending_q <= 1'b0;
            have_next_q <= 1'b0;
            next_q <= '0;
            shift_q <= '0;
            bitn_q <= FIRST_BIT;
            sda_oe_q <= 1'b0;
            scl_oe_q <= 1'b0;
        end else begin
            if (xack_s_q[1] != xack_seen_q) begin
                xack_seen_q <= xack_s_q[1];
                next_q <= xfer_q;
                have_next_q <= 1'b1;
                pending_q <= 1'b0;
            end
            unique case (state_q)
                S_IDLE: begin
                    sda_oe_q <= 1'b0;
                    scl_oe_q <= 1'b0;
                    if (start_s_q[1] != start_seen_q) begin
                        start_seen_q <= start_s_q[1];
                        if (en_s_q[1]) begin
                            state_q <= S_START;
                            if (need_fetch) begin
                                req_tg_q <= ~req_tg_q;
                                pending_q <= 1'b1;
                            end
                        end
                    end
                end
                S_START: begin
                    if (tick && phase_q == PH_RISE) begin
                        sda_oe_q <= 1'b1; // RL5
                    end
                    if (tick && phase_q == PH_HIGH) begin
                        scl_oe_q <= 1'b1;
                    end
                    if (tick && phase_q == PH_FALL && have_next_q) begin
                        shift_q <= next_q; // RL5
                        have_next_q <= 1'b0;
                        bitn_q <= FIRST_BIT;
                        state_q <= S_BIT;
                    end
                end
                S_BIT: begin
                    if (tick) begin
                        unique case (phase_q)
                            PH_SETUP: sda_oe_q <= ~shift_q[MSB];
                            PH_RISE: scl_oe_q <= 1'b0;
                            PH_HIGH: scl_oe_q <= 1'b0;
                            PH_FALL: begin
                                scl_oe_q <= 1'b1;
                                shift_q <= {shift_q[MSB-1:0], 1'b0}; // RL7 RL13
                                bitn_q <= bitn_q + 1'b1;
                                if (bitn_q == FIRST_BIT) begin
                                    first_bit_tg_q <= ~first_bit_tg_q; // RL6 RL12
                                    if (need_fetch) begin
                                        req_tg_q <= ~req_tg_q;
                                        pending_q <= 1'b1;
                                    end
                                end
                                if (bitn_q == LAST_BIT) begin
                                    state_q <= S_ACK;
                                end
                            end
                        endcase
                    end
                end
                S_ACK: begin
                    if (tick) begin
                        unique case (phase_q)
                            PH_SETUP: sda_oe_q <= 1'b0;
                            PH_RISE: scl_oe_q <= 1'b0;
                            PH_HIGH: begin
                                ack_val_q <= ~sda_s_q[1]; // RL8
                                ack_tg_q <= ~ack_tg_q;
                            end
                            PH_FALL: begin
                                scl_oe_q <= 1'b1;
                                state_q <= S_WAIT;
                            end
                        endcase
                    end
                end
                S_WAIT: begin
                    if (tick && phase_q == PH_FALL) begin
                        if (stop_s_q[1]) begin
                            state_q <= S_STOP; // RL11
                        end else if (ack_val_q && have_next_q) begin
                            shift_q <= next_q; // RL12 RL14
                            have_next_q <= 1'b0;
                            bitn_q <= FIRST_BIT;
                            state_q <= S_BIT;
                        end
                    end
                end
                S_STOP: begin
                    if (tick) begin
                        unique case (phase_q)
                            PH_SETUP: sda_oe_q <= 1'b1;
                            PH_RISE: scl_oe_q <= 1'b0;
                            PH_HIGH: sda_oe_q <= 1'b0; // RL11
                            PH_FALL: begin
                                stop_tg_q <= ~stop_tg_q; // RL11
                                have_next_q <= 1'b0;
                                state_q <= S_IDLE;
                            end
                        endcase
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule // ten_bit_tx

// [verif/ten_bit_tx_sva.sv]
// port assertions for the ten-bit address transmit controller
`timescale 1ns/1ps
module ten_bit_tx_sva
    import ten_bit_tx_pkg::*;
(
    // clocks and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic link_clk,
    // control
    input wire logic controller_enable,
    input wire logic transmit_interrupt_enable,
    input wire logic start_req,
    input wire logic stop_req,
    input wire logic flush_req,
    input wire logic data_valid,
    // status and pins
    input wire logic data_ready,
    input wire tx_status_s status,
    input wire logic irq,
    input wire logic sda_oe,
    input wire logic scl_oe
);
    logic [11:0] stop_wait_q;

    // cycles spent with a stop pending
    always_ff @(posedge clk) begin
        if (rst || !status.stop_pending) begin
            stop_wait_q <= 12'h0;
        end else begin
            stop_wait_q <= stop_wait_q + 12'h1;
        end
    end

    a_irq_empty: assert property (@(posedge clk) disable iff (rst)
        (controller_enable && transmit_interrupt_enable && status.transmit_data_empty) [*2]
        |-> irq) else $error("irq missing while empty");
    a_irq_nack: assert property (@(posedge clk) disable iff (rst)
        (controller_enable && transmit_interrupt_enable && status.nack_interrupt_flag) [*2]
        |-> irq) else $error("irq missing on nack");
    a_irq_off: assert property (@(posedge clk) disable iff (rst)
        !controller_enable |=> !irq) else $error("irq while disabled");
    a_write_clears: assert property (@(posedge clk) disable iff (rst)
        data_valid && data_ready && !flush_req && !sda_oe && !scl_oe
        |=> !status.transmit_data_empty) else $error("empty flag kept after write");
    a_start_bus: assert property (@(posedge clk) disable iff (rst)
        start_req && controller_enable && !sda_oe && !scl_oe
        |-> ##[1:1000] (sda_oe && !scl_oe)) else $error("no start condition");
    a_stop_flag: assert property (@(posedge clk) disable iff (rst)
        stop_req && !status.stop_pending |=> status.stop_pending) else $error("stop not held");
    a_stop_bound: assert property (@(posedge clk) disable iff (rst)
        stop_wait_q < 12'hbb8) else $error("stop never completes");
    a_stop_clears: assert property (@(posedge clk) disable iff (rst)
        $fell(status.stop_pending) |-> !status.nack_interrupt_flag) else $error("nack kept");
    a_nack_ack: assert property (@(posedge clk) disable iff (rst)
        $rose(status.nack_interrupt_flag) |-> !status.ack) else $error("ack with nack");
    a_flush_empty: assert property (@(posedge clk) disable iff (rst)
        flush_req |-> ##[1:2] status.transmit_data_empty) else $error("flush left data");
    a_scl_high: assert property (@(posedge link_clk) disable iff (rst)
        $fell(scl_oe) |-> !scl_oe [*8]) else $error("clock high too short");
endmodule // ten_bit_tx_sva

bind ten_bit_tx ten_bit_tx_sva sva_u (.clk, .rst, .link_clk, .controller_enable,
    .transmit_interrupt_enable, .start_req, .stop_req, .flush_req, .data_valid,
    .data_ready, .status, .irq, .sda_oe, .scl_oe);

// [verif/bus_slave_model.sv]
// behavioural slave on the two-wire bus
`timescale 1ns/1ps
module bus_slave_model (
    // bus levels
    input wire logic scl,
    input wire logic sda,
    // behaviour
    input wire logic ack_en,
    // pull and observation
    output logic sda_pull,
    output logic [7:0] last_byte,
    output int bit_count,
    output int byte_count,
    output int stop_count
);
    logic [7:0] shift_q;

    initial begin
        sda_pull = 1'h0;
        last_byte = 8'h0;
        shift_q = 8'h0;
        bit_count = 0;
        byte_count = 0;
        stop_count = 0;
    end
    // start restarts the bit count
    always @(negedge sda) if (scl) bit_count = 0;
    always @(posedge sda) begin
        if (scl) begin
            stop_count++;
            bit_count = 0;
        end
    end
    // bits taken msb first on clock rise
    always @(posedge scl) begin
        if (bit_count < 8) shift_q = {shift_q[6:0], sda};
        bit_count++;
        if (bit_count == 8) begin
            last_byte = shift_q;
            byte_count++;
        end
    end
    // acknowledge slot driven over the ninth bit
    always @(negedge scl) begin
        sda_pull = (bit_count == 8) && ack_en;
        if (bit_count == 9) bit_count = 0;
    end
endmodule // bus_slave_model

// [verif/testbench.sv]
// testbench of the ten-bit address transmit controller
`timescale 1ns/1ps
module testbench
    import ten_bit_tx_pkg::*;
;
    logic clk = 1'h0;
    logic link_clk = 1'h0;
    logic rst, controller_enable, transmit_interrupt_enable, start_req, stop_req;
    logic flush_req, data_valid, ack_en, data_ready, irq, sda_o, sda_oe, scl_o, scl_oe;
    logic sda_pull;
    logic [DATA_W-1:0] data_in;
    logic [7:0] last_byte;
    tx_status_s status;
    wire sda, scl;
    int bit_count, byte_count, stop_count, base, sc, errors, checked;

    assign scl = !scl_oe;
    assign sda = !(sda_oe || sda_pull);
    always #5 clk = ~clk;
    always #3 link_clk = ~link_clk;

    ten_bit_tx dut_u (.clk, .rst, .link_clk, .controller_enable, .transmit_interrupt_enable,
        .start_req, .stop_req, .flush_req, .data_valid, .data_ready, .data_in, .status,
        .irq, .sda_i(sda), .sda_o, .sda_oe, .scl_i(scl), .scl_o, .scl_oe);
    bus_slave_model slave_u (.scl, .sda, .ack_en, .sda_pull, .last_byte, .bit_count,
        .byte_count, .stop_count);

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic put(input logic [7:0] b);
        data_valid = 1'h1;
        data_in = b;
        step(1);
        data_valid = 1'h0;
    endtask
    task automatic wait_irq();
        for (int i = 0; i < 6000 && irq !== 1'h1; i++) step(1);
    endtask
    task automatic wait_bytes(input int n);
        for (int i = 0; i < 12000 && byte_count < n; i++) step(1);
    endtask
    task automatic send_stop();
        stop_req = 1'h1;
        step(1);
        stop_req = 1'h0;
        flush_req = 1'h0;
        for (int i = 0; i < 4000 && status.stop_pending !== 1'h0; i++) step(1);
    endtask
    task automatic t_reset();
        chk(8'(status), 8'h10);
        chk(8'({irq, sda_oe, scl_oe, sda_o, scl_o}), 8'h0);
        chk(8'(data_ready), 8'h1);
    endtask
    task automatic t_fifo();
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            put(8'(i));
            step(1);
        end
        put(8'hee);
        chk(8'(data_ready), 8'h0);
        chk(8'(status.transmit_data_empty), 8'h0);
        flush_req = 1'h1;
        step(1);
        flush_req = 1'h0;
        step(2);
        chk(8'(status.transmit_data_empty), 8'h1);
        chk(8'(data_ready), 8'h1);
    endtask
    task automatic t_irq();
        controller_enable = 1'h1;
        step(3);
        chk(8'(irq), 8'h0);
        transmit_interrupt_enable = 1'h1;
        step(3);
        chk(8'(irq), 8'h1);
        controller_enable = 1'h0;
        start_req = 1'h1;
        step(1);
        start_req = 1'h0;
        step(700);
        chk(8'({irq, sda_oe}), 8'h0);
        controller_enable = 1'h1;
        step(3);
    endtask
    task automatic head(input logic [7:0] b1, input logic [7:0] b2);
        base = byte_count;
        sc = stop_count;
        put(b1);
        step(2);
        chk(8'({status.transmit_data_empty, irq}), 8'h0);
        start_req = 1'h1;
        step(1);
        start_req = 1'h0;
        wait_irq();
        chk(8'(bit_count), 8'h1);
        put(b2);
    endtask
    task automatic t_nack();
        ack_en = 1'h0;
        head(8'hf4, 8'h5a);
        for (int i = 0; i < 12000 && status.nack_interrupt_flag !== 1'h1; i++) step(1);
        step(2);
        chk(8'({status.nack_interrupt_flag, status.ack, irq}), 8'h5);
        chk(last_byte, {TEN_BIT_PREFIX, 2'h2, WRITE_DIR});
        chk(8'(status.header_ten_bit_write), 8'h1);
        flush_req = 1'h1;
        transmit_interrupt_enable = 1'h0;
        send_stop();
        step(2);
        chk(8'(status), 8'h11);
        chk(8'(stop_count - sc), 8'h1);
        chk(8'(byte_count - base), 8'h1);
    endtask
    task automatic t_ack();
        ack_en = 1'h1;
        transmit_interrupt_enable = 1'h1;
        head(8'hf6, 8'h3c);
        for (int i = 0; i < 12000 && status.ack !== 1'h1; i++) step(1);
        chk(8'(status.ack), 8'h1);
        chk(last_byte, 8'hf6);
        wait_irq();
        chk(8'(bit_count), 8'h1);
        chk(8'(byte_count - base), 8'h1);
        put(8'ha5);
        wait_bytes(base + 2);
        chk(last_byte, 8'h3c);
        wait_irq();
        chk(8'(bit_count + byte_count - base), 8'h3);
        wait_bytes(base + 3);
        chk(last_byte, 8'ha5);
        for (int i = 0; i < 3000 && bit_count != 0; i++) step(1);
        step(20);
        chk(8'({status.ack, status.nack_interrupt_flag}), 8'h2);
        send_stop();
        chk(8'(stop_count - sc), 8'h1);
    endtask
    task automatic stop_test();
        if (errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        errors = 0;
        checked = 0;
        {rst, controller_enable, transmit_interrupt_enable, start_req} = 4'h8;
        {stop_req, flush_req, data_valid, ack_en} = 4'h0;
        data_in = 8'h0;
        step(8);
        rst = 1'h0;
        step(3);
        t_reset();
        t_fifo();
        t_irq();
        t_nack();
        t_ack();
        stop_test();
    end
    initial begin
        #1000000;
        errors++;
        stop_test();
    end
endmodule // testbench
